// >>> verilog/dsmux_pkg.sv
/*
  constants for the decoder/spi pin-function mux: function codes, pin slots,
  pull-up bit positions and reset values.
  assumes nothing beyond a SystemVerilog tool.
*/
package dsmux_pkg;
  // ----------------------------------------
  // port c function codes
  // ----------------------------------------
  localparam logic [1:0] FUNC_DECODER = 2'h0;
  localparam logic [1:0] FUNC_TIMER = 2'h1;
  localparam logic [1:0] FUNC_GPIO = 2'h2;
  localparam logic [1:0] FUNC_C_RST = FUNC_DECODER;
  // port e: 0 = spi, 1 = gpio
  localparam logic FUNC_E_RST = 1'h0;

  // ----------------------------------------
  // pin slots and counts
  // ----------------------------------------
  localparam int NUM_C = 3;
  localparam int NUM_E = 3;
  localparam int NUM_PINS = NUM_C + NUM_E;
  localparam int SLOT_C5 = 0;
  localparam int SLOT_C6 = 1;
  localparam int SLOT_C7 = 2;
  localparam int SLOT_E4 = 3;
  localparam int SLOT_E5 = 4;
  localparam int SLOT_E6 = 5;

  // ----------------------------------------
  // pull-up enable register bit positions
  // ----------------------------------------
  localparam int PORT_C_FIRST_BIT = 5;
  localparam int PORT_E_FIRST_BIT = 4;
  localparam int PUR_WIDTH = 8;
  localparam logic PULLUP_RST = 1'h1;

  // ----------------------------------------
  // gpio reset values
  // ----------------------------------------
  localparam logic [NUM_PINS-1:0] GPIO_DIR_RST = 6'h00;
  localparam logic [NUM_PINS-1:0] GPIO_DATA_RST = 6'h00;
endpackage : dsmux_pkg

// >>> verilog/dsmux_pad.sv
/*
  one pad slot: pull-up enable bit and registered drive value and enable.
  assumes the caller has already muxed the function onto drive_*_in.
*/
`timescale 1ns/1ps
module dsmux_pad (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // pull-up write
  input wire logic pullup_wr_in,
  input wire logic pullup_data_in,
  // drive request
  input wire logic drive_out_in,
  input wire logic drive_oe_in,
  // pad side
  output logic pin_out,
  output logic pin_oe_out,
  output logic pullup_out
);
  logic next_pin_out;
  logic next_pin_oe;
  logic next_pullup;

  always_comb begin
    next_pin_out = drive_out_in;
    next_pin_oe = drive_oe_in;
    next_pullup = pullup_wr_in ? pullup_data_in : pullup_out;
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      pin_out <= 1'b0;
      pin_oe_out <= 1'b0;
      pullup_out <= dsmux_pkg::PULLUP_RST; // R16
    end else begin
      pin_out <= next_pin_out;
      pin_oe_out <= next_pin_oe;
      pullup_out <= next_pullup;
    end
  end
endmodule : dsmux_pad

// >>> verilog/dsmux_top.sv
/*
  pin-function mux for decoder 0 pins on port c (5..7) and spi 0 pins on
  port e (4..6): function select, gpio direction, pull-ups, spi directions.
  assumes decoder, timer and spi cores sit outside and the pad ring resolves
  pin_out/pin_oe/pullup into a wire level.
*/
`timescale 1ns/1ps
// Operation
// R1: pc5 resets to phase b; timer1, gpio alternates
// R2: clearing pc pull-up bit 5 disables pull-up
// R3: pc6 resets to index; timer2, gpio alternates
// R4: clearing pc pull-up bit 6 disables pull-up
// R5: pc7 resets to home; timer3, gpio alternates
// R6: clearing pc pull-up bit 7 disables pull-up
// R7: gpio direction programmable per pin
// R8: pe4 resets to spi serial clock
// R9: sclk drives as master, receives as slave
// R10: pe pull-up bits 4..6 disable spi pull-ups
// R11: pe5, pe6 reset to mosi, miso
// R12: mosi out as master; miso opposite
// R13: master mosi leads sampling edge half period
// R14: unselected slave floats miso
// R15: slave miso leads sampling edge half period
// R16: all pull-up enables reset to one
module dsmux_top (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // function select writes
  input wire logic port_c_func_wr_in,
  input wire logic [5:0] port_c_func_data_in,
  input wire logic port_e_func_wr_in,
  input wire logic [2:0] port_e_func_data_in,
  // pull-up enable writes
  input wire logic port_c_pullup_enable_wr_in,
  input wire logic [7:0] port_c_pullup_enable_data_in,
  input wire logic port_e_pullup_enable_wr_in,
  input wire logic [7:0] port_e_pullup_enable_data_in,
  // gpio control
  input wire logic gpio_dir_wr_in,
  input wire logic [5:0] gpio_dir_data_in,
  input wire logic gpio_data_wr_in,
  input wire logic [5:0] gpio_data_data_in,
  // timer a channels 1..3
  input wire logic [2:0] timer_a_drive_in,
  input wire logic [2:0] timer_a_drive_oe_in,
  output logic [2:0] timer_a_channel_out,
  // decoder 0
  output logic decoder0_phase_b_out,
  output logic decoder0_index_out,
  output logic decoder0_home_out,
  // spi 0
  input wire logic spi0_master_in,
  input wire logic spi0_selected_in,
  input wire logic spi0_sclk_drive_in,
  input wire logic spi0_mosi_drive_in,
  input wire logic spi0_miso_drive_in,
  output logic spi0_serial_clock_out,
  output logic spi0_master_out_out,
  output logic spi0_master_in_out,
  // status
  output logic [5:0] port_c_func_out,
  output logic [2:0] port_e_func_out,
  output logic [5:0] gpio_dir_out,
  output logic [5:0] gpio_read_out,
  // pins
  input wire logic [5:0] pin_in,
  output logic [5:0] pin_out,
  output logic [5:0] pin_oe_out,
  output logic [5:0] pin_pullup_out
);
  // ----------------------------------------
  // configuration state
  // ----------------------------------------
  logic [5:0] port_c_func;
  logic [2:0] port_e_gpio;
  logic [5:0] gpio_dir;
  logic [5:0] gpio_data;
  logic [5:0] next_port_c_func;
  logic [2:0] next_port_e_gpio;
  logic [5:0] next_gpio_dir;
  logic [5:0] next_gpio_data;

  always_comb begin
    next_port_c_func = port_c_func_wr_in ? port_c_func_data_in : port_c_func; // R1 R3 R5
    next_port_e_gpio = port_e_func_wr_in ? port_e_func_data_in : port_e_gpio;
    next_gpio_dir = gpio_dir_wr_in ? gpio_dir_data_in : gpio_dir; // R7
    next_gpio_data = gpio_data_wr_in ? gpio_data_data_in : gpio_data;
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      port_c_func <= {3{dsmux_pkg::FUNC_C_RST}}; // R1 R3 R5
      port_e_gpio <= {3{dsmux_pkg::FUNC_E_RST}}; // R8 R11
      gpio_dir <= dsmux_pkg::GPIO_DIR_RST;
      gpio_data <= dsmux_pkg::GPIO_DATA_RST;
    end else begin
      port_c_func <= next_port_c_func;
      port_e_gpio <= next_port_e_gpio;
      gpio_dir <= next_gpio_dir;
      gpio_data <= next_gpio_data;
    end
  end

  // ----------------------------------------
  // per-pin drive selection
  // ----------------------------------------
  // nets: each pin slot drives its own bit from its own generate block
  wire logic [5:0] drive_out;
  wire logic [5:0] drive_oe;
  wire logic [5:0] pullup_wr;
  wire logic [5:0] pullup_data;
  logic [2:0] spi_out;
  logic [2:0] spi_oe;

  // spi drive only; data timing stays the core's, every pin gets one flop
  always_comb begin
    spi_out = {spi0_miso_drive_in, spi0_mosi_drive_in, spi0_sclk_drive_in};
    spi_oe[0] = spi0_master_in; // R9
    spi_oe[1] = spi0_master_in; // R12 R13
    spi_oe[2] = !spi0_master_in && spi0_selected_in; // R12 R14 R15
  end

  genvar g;
  generate
    for (g = 0; g < dsmux_pkg::NUM_C; g++) begin : g_port_c
      logic [1:0] func;
      assign func = port_c_func[2*g +: 2];
      // decoder and code 3 leave the pad undriven
      assign drive_out[g] = (func == dsmux_pkg::FUNC_TIMER) ? timer_a_drive_in[g] :
                            (func == dsmux_pkg::FUNC_GPIO) ? gpio_data[g] : 1'b0;
      assign drive_oe[g] = (func == dsmux_pkg::FUNC_TIMER) ? timer_a_drive_oe_in[g] :
                           (func == dsmux_pkg::FUNC_GPIO) ? gpio_dir[g] : 1'b0; // R7
      assign pullup_wr[g] = port_c_pullup_enable_wr_in;
      assign pullup_data[g] =
        port_c_pullup_enable_data_in[dsmux_pkg::PORT_C_FIRST_BIT + g]; // R2 R4 R6
    end
    for (g = 0; g < dsmux_pkg::NUM_E; g++) begin : g_port_e
      localparam int S = dsmux_pkg::NUM_C + g;
      assign drive_out[S] = port_e_gpio[g] ? gpio_data[S] : spi_out[g];
      assign drive_oe[S] = port_e_gpio[g] ? gpio_dir[S] : spi_oe[g]; // R7 R9 R12
      assign pullup_wr[S] = port_e_pullup_enable_wr_in;
      assign pullup_data[S] =
        port_e_pullup_enable_data_in[dsmux_pkg::PORT_E_FIRST_BIT + g]; // R10
    end
    for (g = 0; g < dsmux_pkg::NUM_PINS; g++) begin : g_pad
      dsmux_pad u_pad (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .pullup_wr_in(pullup_wr[g]),
        .pullup_data_in(pullup_data[g]),
        .drive_out_in(drive_out[g]),
        .drive_oe_in(drive_oe[g]),
        .pin_out(pin_out[g]),
        .pin_oe_out(pin_oe_out[g]),
        .pullup_out(pin_pullup_out[g])
      );
    end
  endgenerate

  // ----------------------------------------
  // input routing, registered
  // ----------------------------------------
  // a pin not on a function feeds it the idle pulled-up level
  logic [2:0] next_dec;
  logic [2:0] next_tmr;
  logic [2:0] next_spi;
  logic [2:0] dec;

  always_comb begin
    for (int i = 0; i < dsmux_pkg::NUM_C; i++) begin
      next_dec[i] = (port_c_func[2*i +: 2] == dsmux_pkg::FUNC_DECODER) ? pin_in[i] : 1'b1;
      next_tmr[i] = (port_c_func[2*i +: 2] == dsmux_pkg::FUNC_TIMER) ? pin_in[i] : 1'b1;
      next_spi[i] = port_e_gpio[i] ? 1'b1 : pin_in[dsmux_pkg::NUM_C + i];
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      dec <= 3'h7;
      timer_a_channel_out <= 3'h7;
      spi0_serial_clock_out <= 1'b1;
      spi0_master_out_out <= 1'b1;
      spi0_master_in_out <= 1'b1;
      gpio_read_out <= 6'h00;
    end else begin
      dec <= next_dec; // R1 R3 R5
      timer_a_channel_out <= next_tmr;
      spi0_serial_clock_out <= next_spi[0]; // R9
      spi0_master_out_out <= next_spi[1];
      spi0_master_in_out <= next_spi[2];
      gpio_read_out <= pin_in;
    end
  end

  assign decoder0_phase_b_out = dec[0];
  assign decoder0_index_out = dec[1];
  assign decoder0_home_out = dec[2];
  assign port_c_func_out = port_c_func;
  assign port_e_func_out = port_e_gpio;
  assign gpio_dir_out = gpio_dir;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  a_reset_funcs: assert property ($rose(rst_n_in) |-> port_c_func == 6'h00 // R1
    && port_e_gpio == 3'h0) else $error("functions not at reset default");
  a_idx_home_dec: assert property (port_c_func[5:2] == 4'h0 |=> // R3
    decoder0_index_out == $past(pin_in[1]) && decoder0_home_out == $past(pin_in[2]))
    else $error("index or home not routed");
  a_phase_b_dec: assert property (port_c_func[1:0] == dsmux_pkg::FUNC_DECODER |=> // R1
    decoder0_phase_b_out == $past(pin_in[0])) else $error("phase b not routed");
  a_pullup_reset: assert property ($rose(rst_n_in) |-> pin_pullup_out == 6'h3f) // R16
    else $error("pull-up not enabled after reset");
  a_pc_pullup_clr: assert property (port_c_pullup_enable_wr_in // R2
    && port_c_pullup_enable_data_in[7:5] == 3'h0 |=> pin_pullup_out[2:0] == 3'h0)
    else $error("port c pull-up not cleared");
  a_pe_pullup_clr: assert property (port_e_pullup_enable_wr_in // R10
    && !port_e_pullup_enable_data_in[4] |=> !pin_pullup_out[3] [*1] ##0 1'b1)
    else $error("sclk pull-up not cleared");
  a_pullup_hold: assert property (!port_c_pullup_enable_wr_in // R6
    |=> pin_pullup_out[2:0] == $past(pin_pullup_out[2:0]))
    else $error("port c pull-up changed without write");
  a_gpio_dir: assert property (port_c_func[3:2] == dsmux_pkg::FUNC_GPIO // R7
    |=> pin_oe_out[1] == $past(gpio_dir[1])) else $error("gpio direction wrong");
  a_sclk_dir: assert property (!port_e_gpio[0] |=> pin_oe_out[3] == $past(spi0_master_in)) // R9
    else $error("sclk direction wrong");
  a_mosi_follow: assert property (!port_e_gpio[1] && spi0_master_in // R13
    |=> pin_oe_out[4] && pin_out[4] == $past(spi0_mosi_drive_in))
    else $error("mosi not driven as master");
  a_miso_float: assert property (!port_e_gpio[2] && !spi0_selected_in // R14
    |=> !pin_oe_out[5]) else $error("unselected miso driven");
  a_miso_slave: assert property (!port_e_gpio[2] && !spi0_master_in // R15
    && spi0_selected_in |=> pin_oe_out[5] && pin_out[5] == $past(spi0_miso_drive_in))
    else $error("selected slave miso not driven");
  a_mosi_slave: assert property (!port_e_gpio[1] && !spi0_master_in // R12
    |=> !pin_oe_out[4]) else $error("mosi driven as slave");

  c_timer_mode: cover property (port_c_func[1:0] == dsmux_pkg::FUNC_TIMER ##1 pin_oe_out[0]);
  c_spi_master: cover property (spi0_master_in && !port_e_gpio[1] ##1 pin_oe_out[4]);
  c_slave_sel: cover property (!spi0_master_in && spi0_selected_in ##1 pin_oe_out[5]);
  c_pullup_off: cover property (port_e_pullup_enable_wr_in ##1 !pin_pullup_out[5]);
endmodule : dsmux_top

// >>> bench/dsmux_peer.sv
/*
  far side of the six pads: sensors and spi peer, resolving each wire level.
  assumes the bench sets peer drive at the falling edge, half a period ahead.
*/
`timescale 1ns/1ps
module dsmux_peer (
  // clock
  input wire logic clk_in,
  // design pad side
  input wire logic [5:0] pin_out,
  input wire logic [5:0] pin_oe_out,
  input wire logic [5:0] pin_pullup_out,
  // peer drive
  input wire logic [5:0] ext_val_in,
  input wire logic [5:0] ext_oe_in,
  input wire logic slave_sel_in,
  output logic [5:0] level_out
);
  logic [5:0] last;
  logic [5:0] peer_oe;

  // peer miso floats while its slave is not selected
  assign peer_oe = {ext_oe_in[5] & slave_sel_in, ext_oe_in[4:0]};
  // undriven without pull-up: inverse of last level, not a held value
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      level_out[i] = pin_oe_out[i] ? pin_out[i] : peer_oe[i] ? ext_val_in[i] :
                     pin_pullup_out[i] ? 1'b1 : ~last[i];
    end
  end
  always_ff @(posedge clk_in) begin
    last <= level_out;
  end
endmodule : dsmux_peer

// >>> bench/testbench.sv
/*
  self-checking bench for the decoder/spi pin-function mux.
  assumes one-cycle config registers and one flop on every pad path.
*/
`timescale 1ns/1ps
module testbench;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic cf_wr = 1'b0, ef_wr = 1'b0, cp_wr = 1'b0, ep_wr = 1'b0, dr_wr = 1'b0, dt_wr = 1'b0;
  logic [5:0] cf_d = 6'h00, dr_d = 6'h00, dt_d = 6'h00, ext_v = 6'h00, ext_oe = 6'h00;
  logic [2:0] ef_d = 3'h0, tm_d = 3'h0, tm_oe = 3'h0, tm_q, e_f;
  logic [7:0] cp_d = 8'h00, ep_d = 8'h00;
  logic mst = 1'b0, sel = 1'b0, psel = 1'b0, sck = 1'b0, mosi = 1'b0, miso = 1'b0;
  logic [5:0] c_f, g_dir, g_rd, p_in, p_out, p_oe, p_pu;
  logic ph_b, idx, home, sck_q, mosi_q, miso_q;
  int err_count = 0;
  int checked = 0;

  dsmux_top i_dsmux_top (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .port_c_func_wr_in(cf_wr), .port_c_func_data_in(cf_d),
    .port_e_func_wr_in(ef_wr), .port_e_func_data_in(ef_d),
    .port_c_pullup_enable_wr_in(cp_wr), .port_c_pullup_enable_data_in(cp_d),
    .port_e_pullup_enable_wr_in(ep_wr), .port_e_pullup_enable_data_in(ep_d),
    .gpio_dir_wr_in(dr_wr), .gpio_dir_data_in(dr_d), .gpio_data_wr_in(dt_wr),
    .gpio_data_data_in(dt_d), .timer_a_drive_in(tm_d), .timer_a_drive_oe_in(tm_oe),
    .timer_a_channel_out(tm_q), .decoder0_phase_b_out(ph_b), .decoder0_index_out(idx),
    .decoder0_home_out(home), .spi0_master_in(mst), .spi0_selected_in(sel),
    .spi0_sclk_drive_in(sck), .spi0_mosi_drive_in(mosi), .spi0_miso_drive_in(miso),
    .spi0_serial_clock_out(sck_q), .spi0_master_out_out(mosi_q),
    .spi0_master_in_out(miso_q), .port_c_func_out(c_f), .port_e_func_out(e_f),
    .gpio_dir_out(g_dir), .gpio_read_out(g_rd), .pin_in(p_in), .pin_out(p_out),
    .pin_oe_out(p_oe), .pin_pullup_out(p_pu));
  dsmux_peer i_dsmux_peer (.clk_in(clk_in), .pin_out(p_out), .pin_oe_out(p_oe),
    .pin_pullup_out(p_pu), .ext_val_in(ext_v), .ext_oe_in(ext_oe),
    .slave_sel_in(psel), .level_out(p_in));

  initial begin
    forever #5 clk_in = ~clk_in;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic step(input int n);
    repeat (n) @(negedge clk_in);
  endtask : step
  task automatic chk(input logic [5:0] got, input logic [5:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic conclude;
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    chk(c_f, 6'h00);
    chk(6'(e_f), 6'h00);
    chk(p_pu, 6'h3f);
    chk(6'({home, idx, ph_b}), 6'h07);
    $display("reset test done");
  endtask : t_reset
  task automatic t_pullup;
    cp_wr = 1'b1; cp_d = 8'h40; step(1); cp_wr = 1'b0;
    ep_wr = 1'b1; ep_d = 8'h2f; step(1); ep_wr = 1'b0;
    chk(p_pu, 6'h12);
    cp_wr = 1'b1; ep_wr = 1'b1; cp_d = 8'hff; ep_d = 8'hff; step(1);
    cp_wr = 1'b0; ep_wr = 1'b0; step(1);
    chk(p_pu, 6'h3f);
    $display("pull-up test done");
  endtask : t_pullup
  task automatic t_decoder;
    // peer changes half a period before the sampling edge
    ext_oe = 6'h07; ext_v = 6'h05; step(2);
    chk(6'({home, idx, ph_b}), 6'h05);
    ext_v = 6'h02; step(2);
    chk(6'({home, idx, ph_b}), 6'h02);
    chk(p_oe, 6'h00);
    ext_oe = 6'h00;
    $display("decoder test done");
  endtask : t_decoder
  task automatic t_timer;
    cf_wr = 1'b1; cf_d = 6'h15; tm_oe = 3'h5; tm_d = 3'h1; step(1); cf_wr = 1'b0; step(2);
    chk(6'(p_oe[2:0]), 6'h05);
    chk(6'(tm_q), 6'h03);
    chk(6'({home, idx, ph_b}), 6'h07);
    // code 3 parks the pins: peer pulls them low, functions must still see idle high
    cf_wr = 1'b1; cf_d = 6'h3f; ext_oe = 6'h07; ext_v = 6'h00; step(1); cf_wr = 1'b0; step(2);
    chk(6'(p_oe[2:0]), 6'h00);
    chk(6'(tm_q), 6'h07);
    chk(6'({home, idx, ph_b}), 6'h07);
    tm_oe = 3'h0;
    ext_oe = 6'h00;
    $display("timer test done");
  endtask : t_timer
  task automatic t_gpio;
    cf_wr = 1'b1; ef_wr = 1'b1; dr_wr = 1'b1; dt_wr = 1'b1;
    cf_d = 6'h2a; ef_d = 3'h7; dr_d = 6'h29; dt_d = 6'h3c; step(1);
    cf_wr = 1'b0; ef_wr = 1'b0; dt_wr = 1'b0; dr_d = 6'h16; step(1);
    chk(p_oe, 6'h29);
    chk(g_dir, 6'h16);
    chk(c_f, 6'h2a);
    chk(6'(e_f), 6'h07);
    chk(p_out & 6'h29, 6'h28);
    dr_wr = 1'b0; ext_oe = 6'h29; ext_v = 6'h21; step(2);
    chk(p_oe, 6'h16);
    chk(g_rd, 6'h35);
    chk(6'({sck_q, mosi_q, miso_q}), 6'h07);
    cf_wr = 1'b1; ef_wr = 1'b1; cf_d = 6'h00; ef_d = 3'h0; ext_oe = 6'h00; step(1);
    cf_wr = 1'b0; ef_wr = 1'b0;
    $display("gpio test done");
  endtask : t_gpio
  task automatic t_spi;
    // master: peer slave answers on miso only while selected
    mst = 1'b1; sck = 1'b1; mosi = 1'b1; psel = 1'b1; ext_oe = 6'h20; ext_v = 6'h00; step(3);
    chk(6'(p_oe[5:3]), 6'h03);
    chk(6'(p_out[4:3]), 6'h03);
    chk(6'(miso_q), 6'h00);
    psel = 1'b0; step(2);
    chk(6'(miso_q), 6'h01);
    mst = 1'b0; sel = 1'b1; miso = 1'b1; ext_oe = 6'h18; ext_v = 6'h08; step(3);
    chk(6'(p_oe[5:3]), 6'h04);
    chk(6'(p_out[5]), 6'h01);
    chk(6'({mosi_q, sck_q}), 6'h01);
    sel = 1'b0; step(1);
    chk(6'(p_oe[5:3]), 6'h00);
    $display("spi test done");
  endtask : t_spi

  initial begin
    step(8);
    rst_n_in = 1'b1;
    step(1);
    t_reset();
    t_pullup();
    t_decoder();
    t_timer();
    t_gpio();
    t_spi();
    conclude();
  end
endmodule : testbench
